// File: hdl/link_regs.vh
`ifndef LINK_REGS_VH
`define LINK_REGS_VH

// ----------------------------------------------------------------
// register offsets (6-bit word index on the register port)
// ----------------------------------------------------------------
`define OFS_DEST 6'h00
`define OFS_SLOTS 6'h19
`define OFS_SRC 6'h2a
`define OFS_AUTO 6'h3a
`define OFS_MODE 6'h3c
`define OFS_RETRY 6'h30
`define OFS_STREAM 6'h31
`define OFS_PKT 6'h32
`define OFS_SLOTLEN 6'h33
`define OFS_ACKWAIT 6'h34
`define OFS_LISTEN 6'h35
`define OFS_STATUS 6'h36
`define OFS_ABANDON 6'h37

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define RST_DEST 16'h0000
`define RST_SRC 16'hffff
`define RST_MODE 8'h00
`define RST_SLOTS 8'h00
`define RST_RETRY 8'h00
`define RST_STREAM 16'hffff
`define RST_PKT 16'h0100
`define RST_SLOTLEN 16'h03e8
`define RST_ACKWAIT 16'h0200
`define RST_LISTEN 16'h0200
`define RST_LFSR 16'hace1

// ----------------------------------------------------------------
// encodings and timing figures
// ----------------------------------------------------------------
`define BROADCAST 16'hffff
`define MODE_REPEATER 8'h03
`define MODE_DEST_ONLY 8'h04
`define RSSI_TOP 9'h029
`define RSSI_FLOOR 9'h064
`define SLOT_SCALE 12'h00a
`define HOLD_SPAN ((`RSSI_TOP + `RSSI_FLOOR) / 9'h00a)

// ----------------------------------------------------------------
// status field positions
// ----------------------------------------------------------------
`define ST_EVENT 0
`define ST_REPEAT 1
`define ST_LISTEN 2
`define ST_RETRY 3
`define ST_TRIES 8

`endif

// File: hdl/pid_history.v
// ----------------------------------------------------------------
// identifier history: fifo of recent packet identifiers
// ----------------------------------------------------------------
module pid_history #(
	parameter DEPTH = 8,
	parameter PTRW = 3,
	parameter IDW = 24
) (
	input wire sys_clk,
	input wire srst,
	input wire [IDW-1:0] lookupId,
	output wire hit,
	input wire push,
	input wire [IDW-1:0] pushId
);
	reg [IDW-1:0] entry [0:DEPTH-1];
	reg [DEPTH-1:0] used;
	reg [PTRW-1:0] wrPtr;
	wire [DEPTH-1:0] match;

	// one comparator per entry; unused slots never match after reset
	genvar i;
	generate
		for (i = 0; i < DEPTH; i = i + 1) begin : cmp
			assign match[i] = used[i] && (entry[i] == lookupId); // [RQ2]
		end
	endgenerate
	assign hit = |match;

	// oldest entry overwritten first; pointer wraps, so DEPTH is a power of two
	always @(posedge sys_clk) begin
		if (srst) begin
			used <= {DEPTH{1'b0}};
			wrPtr <= {PTRW{1'b0}};
		end else if (push) begin
			used[wrPtr] <= 1'b1;
			wrPtr <= wrPtr + 1'b1; // [RQ3]
		end
	end

	// storage itself needs no reset, the used bits guard it
	always @(posedge sys_clk) begin
		if (push) begin
			entry[wrPtr] <= pushId;
		end
	end
endmodule // pid_history

// File: hdl/repeater_ack_link.v
// Functional notes
// [RQ1] - identifier is source address plus serial
// [RQ2] - drop packets already in identifier history
// [RQ3] - history keeps last 8 identifiers, fifo
// [RQ4] - repeat every new packet, deliver on match
// [RQ5] - stronger reception gets earlier repeat slot
// [RQ6] - repeat slots from rssi plus random
// [RQ7] - hold off new host data for repeats
// [RQ8] - mode 3 repeats, mode 4 waits quiet
// [RQ9] - auto-address derives source from factory serial
// [RQ10] - destination all ones means broadcast
// [RQ11] - delay slots at 0x19, source resets ffff
// [RQ12] - after ack send next or wait slots
// [RQ13] - no ack: retry, later retries random back-off
// [RQ14] - zero slots no back-off, wait for rx
// [RQ15] - after ack hop and listen fixed window
// [RQ16] - ack every copy, deliver first only
// [RQ17] - thresholds gate first packet of event only
// [RQ18] - payload never exceeds max packet size
// [RQ19] - stream limit forces 1 to n slots
// [RQ20] - retries count once toward stream limit
// [RQ21] - initializer on first packet and retries only; repeat launches also set txInit
// [RQ22] - receiver waits random 0 to n-1 slots
// [RQ23] - abandon packet after retries exhausted
// [RQ24] - deliver only when all three filters pass
`include "link_regs.vh"

module repeater_ack_link (
	input wire sys_clk,
	input wire srst,
	input wire [5:0] regAddr,
	input wire [15:0] regWrData,
	input wire regWr,
	input wire regRd,
	output reg [15:0] regRdData,
	input wire [31:0] factorySerial,
	input wire [15:0] inBufCount,
	input wire packetizeHit,
	output reg bufTake,
	output reg txStart,
	output reg [15:0] txLen,
	output reg txInit,
	output reg txRepeat,
	output reg [23:0] txPid,
	input wire txDone,
	input wire rxActive,
	input wire rxValid,
	input wire [15:0] rxSrcAddr,
	input wire [7:0] rxSerial,
	input wire [15:0] rxDestAddr,
	input wire [7:0] rxRssi,
	input wire rxPreambleOk,
	input wire rxVendorOk,
	input wire rxIsAck,
	input wire rxAckReq,
	input wire rxLast,
	output reg deliver,
	output reg ackSend,
	output reg hopNext
);
	localparam S_IDLE = 7'b0000001;
	localparam S_HOLD = 7'b0000010;
	localparam S_SEND = 7'b0000100;
	localparam S_AIR = 7'b0001000;
	localparam S_ACKW = 7'b0010000;
	localparam S_BACK = 7'b0100000;
	localparam S_REP = 7'b1000000;

	// ----------------------------------------------------------------
	// configuration and state
	// ----------------------------------------------------------------
	reg [15:0] destinationAddress;
	reg [15:0] sourceAddress;
	reg [7:0] rfOperatingMode;
	reg [7:0] delaySlotCount;
	reg [7:0] retryCount;
	reg [15:0] streamingByteLimit;
	reg [15:0] maxPacketSize;
	reg [15:0] slotLen;
	reg [15:0] ackWait;
	reg [15:0] listenLen;
	reg [31:0] serialMeta;
	reg [31:0] serialSync;
	reg [15:0] lfsr;
	reg [6:0] state;
	reg [31:0] waitLeft;
	reg [15:0] eventBytes;
	reg [7:0] tries;
	reg firstPkt;
	reg retryPkt;
	reg [15:0] abandonCnt;
	reg repPending;
	reg [31:0] repLeft;
	reg [23:0] repPid;
	reg [15:0] listenLeft;

	// ----------------------------------------------------------------
	// derived values
	// ----------------------------------------------------------------
	wire [15:0] rnExt = {8'h00, delaySlotCount};
	wire [15:0] rnPlus = rnExt + 16'h0001;
	wire [15:0] randInc = lfsr % rnPlus;
	wire [15:0] randExc = (delaySlotCount == 8'h00) ? 16'h0000 : (lfsr % rnExt);
	wire [15:0] randOne = (delaySlotCount == 8'h00) ? 16'h0001 : ((lfsr % rnExt) + 16'h0001);
	wire [15:0] holdSlots = rnExt * `HOLD_SPAN + rnExt + 16'h0001;
	wire [31:0] holdCycles = holdSlots * slotLen;
	wire ackedMode = (retryCount != 8'h00);
	wire netMode = (rfOperatingMode == `MODE_REPEATER) || (rfOperatingMode == `MODE_DEST_ONLY);
	wire listenOn = (listenLeft != 16'h0000);
	wire [15:0] streamLeft = (eventBytes >= streamingByteLimit) ? 16'h0000 : (streamingByteLimit - eventBytes);
	wire [15:0] lenA = (inBufCount < maxPacketSize) ? inBufCount : maxPacketSize;
	wire [15:0] lenNext = (lenA < streamLeft) ? lenA : streamLeft;

	// weak signal gives a large gap and so a late repeat slot
	wire [8:0] rssiMag = rxRssi[7] ? ({1'b0, ~rxRssi} + 9'h001) : 9'h000;
	wire [8:0] rssiGap = (rssiMag > `RSSI_TOP) ? (rssiMag - `RSSI_TOP) : 9'h000; // [RQ5]
	wire [11:0] slotDiv = {4'h0, delaySlotCount} * `SLOT_SCALE;
	wire [11:0] rssiSlots = (delaySlotCount == 8'h00) ? 12'h000 : ({3'h0, rssiGap} / slotDiv);
	wire [15:0] repSlots = {4'h0, rssiSlots} + randInc; // [RQ6]

	// ----------------------------------------------------------------
	// receive classification
	// ----------------------------------------------------------------
	wire [23:0] rxPid = {rxSrcAddr, rxSerial}; // [RQ1]
	wire pidHit;
	wire filtersOk = rxPreambleOk && rxVendorOk; // [RQ24]
	wire dataIn = rxValid && filtersOk && !rxIsAck;
	wire newPkt = dataIn && !pidHit; // [RQ2]
	wire isBroadcast = (rxDestAddr == `BROADCAST); // [RQ10]
	wire isLocal = !isBroadcast && (rxDestAddr == sourceAddress);
	wire ackIn = rxValid && filtersOk && rxIsAck && (rxDestAddr == sourceAddress);
	wire rxEventEnd = dataIn && rxLast;

	pid_history #(
		.DEPTH(8),
		.PTRW(3),
		.IDW(24)
	) history (
		.sys_clk(sys_clk),
		.srst(srst),
		.lookupId(rxPid),
		.hit(pidHit),
		.push(newPkt),
		.pushId(rxPid)
	);

	// ----------------------------------------------------------------
	// factory serial pin sync and random source
	// ----------------------------------------------------------------
	// serial pins are asynchronous, two stages before use
	always @(posedge sys_clk) begin
		if (srst) begin
			serialMeta <= 32'h00000000;
			serialSync <= 32'h00000000;
			lfsr <= `RST_LFSR;
		end else begin
			serialMeta <= factorySerial;
			serialSync <= serialMeta;
			lfsr <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
		end
	end

	// ----------------------------------------------------------------
	// register writes
	// ----------------------------------------------------------------
	// folded serial; all-ones would read as broadcast, so it is bumped down
	wire [15:0] autoAddr = serialSync[31:16] ^ serialSync[15:0];
	always @(posedge sys_clk) begin
		if (srst) begin
			destinationAddress <= `RST_DEST;
			sourceAddress <= `RST_SRC; // [RQ11]
			rfOperatingMode <= `RST_MODE;
			delaySlotCount <= `RST_SLOTS; // [RQ11]
			retryCount <= `RST_RETRY;
			streamingByteLimit <= `RST_STREAM;
			maxPacketSize <= `RST_PKT;
			slotLen <= `RST_SLOTLEN;
			ackWait <= `RST_ACKWAIT;
			listenLen <= `RST_LISTEN;
		end else if (regWr) begin
			case (regAddr)
				`OFS_DEST: destinationAddress <= regWrData;
				`OFS_SRC: sourceAddress <= regWrData;
				`OFS_AUTO: sourceAddress <= (autoAddr == `BROADCAST) ? 16'hfffe : autoAddr; // [RQ9]
				`OFS_MODE: rfOperatingMode <= regWrData[7:0];
				`OFS_SLOTS: delaySlotCount <= regWrData[7:0]; // [RQ11]
				`OFS_RETRY: retryCount <= regWrData[7:0];
				`OFS_STREAM: streamingByteLimit <= regWrData;
				`OFS_PKT: maxPacketSize <= regWrData;
				`OFS_SLOTLEN: slotLen <= regWrData;
				`OFS_ACKWAIT: ackWait <= regWrData;
				`OFS_LISTEN: listenLen <= regWrData;
				default: sourceAddress <= sourceAddress;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// register reads, data valid one cycle after the strobe
	// ----------------------------------------------------------------
	always @(posedge sys_clk) begin
		if (srst) begin
			regRdData <= 16'h0000;
		end else if (regRd) begin
			case (regAddr)
				`OFS_DEST: regRdData <= destinationAddress;
				`OFS_SRC: regRdData <= sourceAddress;
				`OFS_MODE: regRdData <= {8'h00, rfOperatingMode};
				`OFS_SLOTS: regRdData <= {8'h00, delaySlotCount};
				`OFS_RETRY: regRdData <= {8'h00, retryCount};
				`OFS_STREAM: regRdData <= streamingByteLimit;
				`OFS_PKT: regRdData <= maxPacketSize;
				`OFS_SLOTLEN: regRdData <= slotLen;
				`OFS_ACKWAIT: regRdData <= ackWait;
				`OFS_LISTEN: regRdData <= listenLen;
				`OFS_STATUS: regRdData <= {tries, 4'h0, retryPkt, listenOn, repPending, !state[0]};
				`OFS_ABANDON: regRdData <= abandonCnt;
				default: regRdData <= 16'h0000;
			endcase
		end else begin
			regRdData <= 16'h0000;
		end
	end

	// ----------------------------------------------------------------
	// receive side: delivery, acks, repeat scheduling, listen window
	// ----------------------------------------------------------------
	// a new repeat request beats the clear from the launch in the same cycle
	always @(posedge sys_clk) begin
		if (srst) begin
			deliver <= 1'b0;
			ackSend <= 1'b0;
			hopNext <= 1'b0;
			repPending <= 1'b0;
			repLeft <= 32'h00000000;
			repPid <= 24'h000000;
			listenLeft <= 16'h0000;
		end else begin
			deliver <= newPkt && (isBroadcast || isLocal); // [RQ4] [RQ16] [RQ24]
			ackSend <= dataIn && rxAckReq && isLocal; // [RQ16]
			hopNext <= dataIn && rxAckReq && isLocal; // [RQ15]
			if (dataIn && rxAckReq && isLocal) begin
				listenLeft <= listenLen; // [RQ15]
			end else if (listenOn) begin
				listenLeft <= listenLeft - 16'h0001;
			end
			if (newPkt && rfOperatingMode == `MODE_REPEATER) begin
				repPending <= 1'b1; // [RQ4] [RQ8]
				repLeft <= repSlots * slotLen; // [RQ6]
				repPid <= rxPid;
			end else begin
				if (txStart && txRepeat) begin
					repPending <= 1'b0;
				end
				if (repLeft != 32'h00000000) begin
					repLeft <= repLeft - 32'h00000001;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// end of packet: next packet, or close the event
	// ----------------------------------------------------------------
	task finish_packet;
		begin
			firstPkt <= 1'b0;
			retryPkt <= 1'b0;
			tries <= 8'h00;
			if (inBufCount != 16'h0000 && eventBytes < streamingByteLimit) begin
				state <= S_SEND; // [RQ12] [RQ17]
			end else if (eventBytes >= streamingByteLimit) begin
				waitLeft <= randOne * slotLen; // [RQ19]
				state <= S_IDLE;
			end else begin
				waitLeft <= rnExt * slotLen; // [RQ12]
				state <= S_IDLE;
			end
		end
	endtask

	// ----------------------------------------------------------------
	// transmit sequencer
	// ----------------------------------------------------------------
	// one waitLeft counter serves hold-off, back-off, ack timeout and quiet time
	always @(posedge sys_clk) begin
		if (srst) begin
			state <= S_IDLE;
			waitLeft <= 32'h00000000;
			eventBytes <= 16'h0000;
			tries <= 8'h00;
			firstPkt <= 1'b0;
			retryPkt <= 1'b0;
			abandonCnt <= 16'h0000;
			bufTake <= 1'b0;
			txStart <= 1'b0;
			txLen <= 16'h0000;
			txInit <= 1'b0;
			txRepeat <= 1'b0;
			txPid <= 24'h000000;
		end else begin
			bufTake <= 1'b0;
			txStart <= 1'b0;
			if (waitLeft != 32'h00000000) begin
				waitLeft <= waitLeft - 32'h00000001;
			end
			case (state)
				S_IDLE: begin
					if (rxEventEnd && delaySlotCount != 8'h00) begin
						waitLeft <= randExc * slotLen; // [RQ22]
					end else if (repPending && repLeft == 32'h00000000 && !rxActive && !listenOn) begin
						txStart <= 1'b1; // [RQ4]
						txRepeat <= 1'b1;
						txInit <= 1'b1;
						txPid <= repPid;
						state <= S_REP;
					end else if (waitLeft == 32'h00000000 && !rxActive && !listenOn &&
						inBufCount != 16'h0000 && packetizeHit) begin // [RQ17]
						eventBytes <= 16'h0000;
						tries <= 8'h00;
						firstPkt <= 1'b1;
						retryPkt <= 1'b0;
						if (netMode) begin
							waitLeft <= holdCycles; // [RQ7]
							state <= S_HOLD;
						end else begin
							state <= S_SEND;
						end
					end
				end
				S_HOLD: begin
					// destination-only nodes restart the wait while the air is busy
					if (rfOperatingMode == `MODE_DEST_ONLY && (rxActive || rxValid)) begin
						waitLeft <= holdCycles; // [RQ8]
					end else if (waitLeft == 32'h00000000) begin
						state <= S_SEND; // [RQ7]
					end
				end
				S_SEND: begin
					if (!rxActive) begin
						txStart <= 1'b1;
						txRepeat <= 1'b0;
						txPid <= {sourceAddress, 8'h00};
						txInit <= firstPkt || retryPkt; // [RQ21] [RQ13]
						if (!retryPkt) begin
							txLen <= lenNext; // [RQ18]
							bufTake <= 1'b1;
							eventBytes <= eventBytes + lenNext; // [RQ20]
						end
						state <= S_AIR;
					end
				end
				S_AIR: begin
					if (txDone) begin
						if (ackedMode) begin
							waitLeft <= {16'h0000, ackWait}; // [RQ12]
							state <= S_ACKW;
						end else begin
							finish_packet;
						end
					end
				end
				S_ACKW: begin
					if (ackIn) begin
						finish_packet; // [RQ12]
					end else if (waitLeft == 32'h00000000) begin
						if (tries < retryCount) begin
							tries <= tries + 8'h01;
							retryPkt <= 1'b1;
							if (tries == 8'h00 || delaySlotCount == 8'h00) begin
								state <= S_SEND; // [RQ13] [RQ14]
							end else begin
								waitLeft <= randInc * slotLen; // [RQ13]
								state <= S_BACK;
							end
						end else begin
							abandonCnt <= abandonCnt + 16'h0001; // [RQ23]
							finish_packet;
						end
					end
				end
				S_BACK: begin
					// reception in progress stretches the back-off
					if (waitLeft == 32'h00000000 && !rxActive) begin
						state <= S_SEND; // [RQ14]
					end
				end
				S_REP: begin
					if (txDone) begin
						txRepeat <= 1'b0;
						state <= S_IDLE;
					end
				end
				default: state <= S_IDLE;
			endcase
		end
	end
endmodule // repeater_ack_link

// File: verification/modem_peer_model.sv
module modem_peer_model (
	input wire sys_clk,
	input wire srst,
	input wire [7:0] airCycles,
	input wire load,
	input wire [15:0] fill,
	input wire txStart,
	input wire bufTake,
	input wire [15:0] txLen,
	output reg txDone = 1'b0,
	output reg [15:0] inBufCount = 16'h0000
);
	timeunit 1ns;
	timeprecision 1ps;
	reg [7:0] airLeft = 8'h00;
	// airtime then one done pulse; a slow air setting stretches every launch
	always @(posedge sys_clk) begin
		txDone <= 1'b0;
		if (srst) begin
			airLeft <= 8'h00;
			inBufCount <= 16'h0000;
		end else begin
			if (txStart)
				airLeft <= airCycles;
			else if (airLeft != 8'h00) begin
				airLeft <= airLeft - 8'h01;
				txDone <= (airLeft == 8'h01);
			end
			// serial input buffer drains only by what was taken
			if (load)
				inBufCount <= fill;
			else if (bufTake)
				inBufCount <= inBufCount - txLen;
		end
	end
endmodule // modem_peer_model

// File: verification/repeater_ack_link_bench.sv
module repeater_ack_link_bench;
	timeunit 1ns;
	timeprecision 1ps;
	reg sys_clk = 1'b0;
	reg srst = 1'b1;
	reg [5:0] regAddr = 6'h00;
	reg [15:0] regWrData = 16'h0000;
	reg regWr = 1'b0;
	reg regRd = 1'b0;
	reg packetizeHit = 1'b0;
	reg rxActive = 1'b0;
	reg rxValid = 1'b0;
	reg [15:0] rxSrcAddr = 16'h0000;
	reg [7:0] rxSerial = 8'h00;
	reg [15:0] rxDestAddr = 16'h0000;
	reg rxPreambleOk = 1'b0;
	reg rxVendorOk = 1'b0;
	reg rxAckReq = 1'b0;
	reg rxIsAck = 1'b0;
	reg load = 1'b0;
	reg [15:0] fill = 16'h0000;
	reg [7:0] airCycles = 8'h04;
	wire [15:0] regRdData, inBufCount, txLen;
	wire [23:0] txPid;
	wire bufTake, txStart, txInit, txRepeat, txDone, deliver, ackSend, hopNext;
	integer err_count = 0;
	integer compares = 0;
	integer cycles = 0;
	integer i;

	// 100 MHz node clock
	always #5 sys_clk = ~sys_clk;

	// serial folds to 0x444c as auto address
	repeater_ack_link i_dut (
		.sys_clk(sys_clk), .srst(srst), .regAddr(regAddr), .regWrData(regWrData),
		.regWr(regWr), .regRd(regRd), .regRdData(regRdData), .factorySerial(32'h12345678),
		.inBufCount(inBufCount), .packetizeHit(packetizeHit), .bufTake(bufTake),
		.txStart(txStart), .txLen(txLen), .txInit(txInit), .txRepeat(txRepeat),
		.txPid(txPid), .txDone(txDone), .rxActive(rxActive), .rxValid(rxValid),
		.rxSrcAddr(rxSrcAddr), .rxSerial(rxSerial), .rxDestAddr(rxDestAddr),
		.rxRssi(8'hd8), .rxPreambleOk(rxPreambleOk), .rxVendorOk(rxVendorOk),
		.rxIsAck(rxIsAck), .rxAckReq(rxAckReq), .rxLast(1'b0), .deliver(deliver),
		.ackSend(ackSend), .hopNext(hopNext)
	);

	modem_peer_model i_peer (
		.sys_clk(sys_clk), .srst(srst), .airCycles(airCycles), .load(load), .fill(fill),
		.txStart(txStart), .bufTake(bufTake), .txLen(txLen), .txDone(txDone),
		.inBufCount(inBufCount)
	);

	// ----------------------------------------------------------------
	// access tasks
	// ----------------------------------------------------------------
	task chk(input [23:0] got, input [23:0] exp);
		begin
			compares = compares + 1;
			if (got !== exp) begin
				err_count = err_count + 1;
				$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
			end
		end
	endtask

	task wr(input [5:0] a, input [15:0] d);
		begin
			@(posedge sys_clk);
			regAddr <= a;
			regWrData <= d;
			regWr <= 1'b1;
			@(posedge sys_clk);
			regWr <= 1'b0;
		end
	endtask

	// data stand only in the cycle after the strobe
	task rd(input [5:0] a, input [15:0] exp);
		begin
			@(posedge sys_clk);
			regAddr <= a;
			regRd <= 1'b1;
			@(posedge sys_clk);
			regRd <= 1'b0;
			#1;
			chk(regRdData, exp);
		end
	endtask

	task rx(input [15:0] s, input [7:0] n, input [15:0] d, input [1:0] f, input a, input eD, input eA);
		begin
			@(posedge sys_clk);
			rxValid <= 1'b1;
			rxActive <= 1'b1;
			rxSrcAddr <= s;
			rxSerial <= n;
			rxDestAddr <= d;
			{rxPreambleOk, rxVendorOk} <= f;
			rxAckReq <= a;
			@(posedge sys_clk);
			rxValid <= 1'b0;
			rxActive <= 1'b0;
			#1;
			chk(deliver, eD);
			chk(ackSend, eA);
		end
	endtask

	task fillBuf(input [15:0] n);
		begin
			@(posedge sys_clk);
			load <= 1'b1;
			fill <= n;
			packetizeHit <= 1'b1;
			@(posedge sys_clk);
			load <= 1'b0;
		end
	endtask

	// ack addressed to the auto address, one cycle long
	task sendAck;
		begin
			@(posedge sys_clk);
			rxValid <= 1'b1;
			rxIsAck <= 1'b1;
			rxDestAddr <= 16'h444c;
			{rxPreambleOk, rxVendorOk} <= 2'b11;
			@(posedge sys_clk);
			rxValid <= 1'b0;
			rxIsAck <= 1'b0;
		end
	endtask

	// the cycle ceiling below cuts a missing launch short
	task waitStart;
		begin
			do begin
				@(posedge sys_clk);
				#1;
			end while (txStart !== 1'b1);
		end
	endtask

	task wrap_up;
		begin
			$display("compares=%0d err_count=%0d", compares, err_count);
			if (err_count == 0 && compares > 0)
				$display("Testbench passed");
			else
				$display("Testbench failed");
			$finish;
		end
	endtask

	// hang guard, far above the few hundred cycles needed
	always @(posedge sys_clk) begin
		cycles = cycles + 1;
		if (cycles == 20000) begin
			err_count = err_count + 1;
			wrap_up;
		end
	end

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (6) @(posedge sys_clk);
		srst <= 1'b0;
		@(posedge sys_clk);
		rd(6'h2a, 16'hffff);
		rd(6'h19, 16'h0000);
		rd(6'h3f, 16'h0000);
		wr(6'h19, 16'h00ff);
		rd(6'h19, 16'h00ff);
		wr(6'h19, 16'h0000);
		wr(6'h3a, 16'h0000);
		rd(6'h2a, 16'h444c);
		// streaming event split by packet size
		wr(6'h32, 16'h0003);
		fillBuf(16'h0005);
		waitStart;
		chk(txLen, 16'h0003);
		chk(txInit, 1'b1);
		chk(bufTake, 1'b1);
		chk(txPid, 24'h444c00);
		@(posedge sys_clk);
		packetizeHit <= 1'b0;
		waitStart;
		chk(txLen, 16'h0002);
		chk(txInit, 1'b0);
		// let the last streamed packet finish before acks are switched on
		repeat (8) @(posedge sys_clk);
		// acked packet never answered: one retry, then abandon
		wr(6'h30, 16'h0001);
		wr(6'h34, 16'h0020);
		airCycles <= 8'h28;
		fillBuf(16'h0002);
		waitStart;
		chk(bufTake, 1'b1);
		@(posedge sys_clk);
		packetizeHit <= 1'b0;
		waitStart;
		chk(bufTake, 1'b0);
		chk(txInit, 1'b1);
		chk(txLen, 16'h0002);
		repeat (150) @(posedge sys_clk);
		rd(6'h37, 16'h0001);
		// answered ack closes the packet well before its timeout
		fillBuf(16'h0001);
		waitStart;
		chk(txLen, 16'h0001);
		@(posedge sys_clk);
		packetizeHit <= 1'b0;
		repeat (45) @(posedge sys_clk);
		sendAck;
		rd(6'h36, 16'h0000);
		rd(6'h37, 16'h0001);
		wr(6'h30, 16'h0000);
		// identifier history, eight deep
		rx(16'h0001, 8'h00, 16'hffff, 2'b11, 1'b0, 1'b1, 1'b0);
		rx(16'h0001, 8'h00, 16'hffff, 2'b11, 1'b0, 1'b0, 1'b0);
		rx(16'h0001, 8'h20, 16'hffff, 2'b10, 1'b0, 1'b0, 1'b0);
		rx(16'h0001, 8'h20, 16'hffff, 2'b01, 1'b0, 1'b0, 1'b0);
		for (i = 1; i < 8; i = i + 1)
			rx(16'h0001, i[7:0], 16'hffff, 2'b11, 1'b0, 1'b1, 1'b0);
		rx(16'h0001, 8'h00, 16'hffff, 2'b11, 1'b0, 1'b0, 1'b0);
		rx(16'h0001, 8'h08, 16'hffff, 2'b11, 1'b0, 1'b1, 1'b0);
		rx(16'h0001, 8'h00, 16'hffff, 2'b11, 1'b0, 1'b1, 1'b0);
		rx(16'h0001, 8'h09, 16'h0002, 2'b11, 1'b0, 1'b0, 1'b0);
		// repeater: foreign packet goes back on air only
		wr(6'h3c, 16'h0003);
		rx(16'h0005, 8'h07, 16'h1111, 2'b11, 1'b0, 1'b0, 1'b0);
		waitStart;
		chk(txRepeat, 1'b1);
		chk(txPid, 24'h000507);
		chk(bufTake, 1'b0);
		chk(txInit, 1'b1);
		// every copy is acked, only the first delivered
		rx(16'h0006, 8'h01, 16'h444c, 2'b11, 1'b1, 1'b1, 1'b1);
		chk(hopNext, 1'b1);
		rx(16'h0006, 8'h01, 16'h444c, 2'b11, 1'b1, 1'b0, 1'b1);
		wrap_up;
	end
endmodule // repeater_ack_link_bench

// File: verification/repeater_ack_link_sva.sv
module repeater_ack_link_sva (
	input wire sys_clk,
	input wire srst,
	input wire regRd,
	input wire [15:0] regRdData,
	input wire [15:0] inBufCount,
	input wire bufTake,
	input wire txStart,
	input wire [15:0] txLen,
	input wire txInit,
	input wire txRepeat,
	input wire [23:0] txPid,
	input wire rxValid,
	input wire rxPreambleOk,
	input wire rxVendorOk,
	input wire rxAckReq,
	input wire deliver,
	input wire ackSend,
	input wire hopNext
);
	timeunit 1ns;
	timeprecision 1ps;
	// ----------------------------------------------------------------
	// link steps
	// ----------------------------------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (srst);
	// a reception that fails either header filter
	sequence s_bad_rx;
		rxValid && !(rxPreambleOk && rxVendorOk);
	endsequence
	// a launch that takes nothing and is no repeat: a retry
	sequence s_retry_launch;
		txStart && !bufTake && !txRepeat;
	endsequence
	a_rdata_idle: assert property (!$past(regRd) |-> regRdData == 16'h0000)
		else $error("read data seen outside its cycle");
	a_hop_with_ack: assert property (ackSend |-> hopNext)
		else $error("ack sent without frequency hop");
	a_deliver_cause: assert property (deliver |-> $past(rxValid && rxPreambleOk && rxVendorOk))
		else $error("delivery without filtered reception");
	a_bad_silent: assert property (s_bad_rx |=> !deliver && !ackSend)
		else $error("filtered packet was answered");
	a_ack_cause: assert property (ackSend |-> $past(rxValid && rxAckReq))
		else $error("ack without requesting packet");
	a_take_own: assert property (bufTake |-> txStart && !txRepeat)
		else $error("buffer take outside own launch");
	a_len_bound: assert property (bufTake |-> txLen != 16'h0000 && txLen <= inBufCount)
		else $error("packet length outside pending bytes");
	a_retry_init: assert property (s_retry_launch |-> txInit)
		else $error("retry launched without initializer");
	a_repeat_init: assert property (txStart && txRepeat |-> txInit)
		else $error("repeat launched without initializer");
	a_fields_held: assert property (!txStart |-> $stable(txLen) && $stable(txPid))
		else $error("launch fields changed between launches");
endmodule // repeater_ack_link_sva

bind repeater_ack_link repeater_ack_link_sva i_sva (
	.sys_clk(sys_clk), .srst(srst), .regRd(regRd), .regRdData(regRdData),
	.inBufCount(inBufCount), .bufTake(bufTake), .txStart(txStart), .txLen(txLen),
	.txInit(txInit), .txRepeat(txRepeat), .txPid(txPid), .rxValid(rxValid),
	.rxPreambleOk(rxPreambleOk), .rxVendorOk(rxVendorOk), .rxAckReq(rxAckReq),
	.deliver(deliver), .ackSend(ackSend), .hopNext(hopNext)
);
